// [common/iopm_regs.vh]
// Register offsets, field positions and reset values of the port pin mux
// What this block does
// - Radio test output drives status on pins 7-4
// - Three test-output registers enable and invert the shown signals
// - Test output overrides config and forces output direction
// - Port 0 data register, bit-addressable, resets to ones
// - Port 1 data register, bit-addressable, resets to ones
// - Port 2 data: pins 4-0, upper bits zero
// - Location bit picks alternative 1 or 2
// - Analog enable makes port 0 pin converter input
// - Port 0 select bit picks GPIO or peripheral
// - Port 1 select bit picks GPIO or peripheral
// - Port 2 selects cover pins 4, 3, 0
// - Bit 6 arbitrates serial zero against serial one
// - Bit 5 arbitrates serial one against timer 3
// - Bit 4 arbitrates timer 1 against timer 4
// - Bit 3 arbitrates serial zero against timer 1
// - Analog enable beats port 0 function select
// - Slow oscillator low takes port 2 pins 3-4
`ifndef IOPM_REGS_VH
`define IOPM_REGS_VH

`define IOPM_PORT0_DATA_ADDR 8'h80
`define IOPM_PORT1_DATA_ADDR 8'h90
`define IOPM_PORT2_DATA_ADDR 8'ha0
`define IOPM_PERIPHERAL_LOCATION_ADDR 8'hf1
`define IOPM_ANALOG_INPUT_ENABLE_ADDR 8'hf2
`define IOPM_PORT0_FUNCTION_SELECT_ADDR 8'hf3
`define IOPM_PORT1_FUNCTION_SELECT_ADDR 8'hf4
`define IOPM_PORT2_SELECT_PRIORITY_ADDR 8'hf5

`define IOPM_PORT0_DATA_RST 8'hff
`define IOPM_PORT1_DATA_RST 8'hff
`define IOPM_PORT2_DATA_RST 5'h1f
`define IOPM_CFG_RST 8'h00

`define IOPM_LOC_MASK 8'h73
`define IOPM_PORT2_SEL_MASK 8'h7f

`define IOPM_LOC_TIMER_A 6
`define IOPM_LOC_TIMER_C 5
`define IOPM_LOC_TIMER_D 4
`define IOPM_LOC_SERIAL_ONE 1
`define IOPM_LOC_SERIAL_ZERO 0

`define IOPM_PRI_SERIAL_PAIR 6
`define IOPM_PRI_SERIAL1_TIMER3 5
`define IOPM_PRI_TIMER1_TIMER4 4
`define IOPM_PRI_SERIAL0_TIMER1 3
`define IOPM_SEL_P2_PIN4 2
`define IOPM_SEL_P2_PIN3 1
`define IOPM_SEL_P2_PIN0 0

`define IOPM_TOC_EN_BIT 6
`define IOPM_TOC_INV_BIT 0

`endif

// [design/iopm_pin_drv.v]
// Per-pin output multiplexer with fixed precedence and registered pin drive
`timescale 1ns/10ps
module iopm_pin_drv #(
  parameter W = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // General purpose side
  input wire [W-1:0] gpio_out,
  input wire [W-1:0] gpio_oe,
  input wire [W-1:0] sel,
  // Peripheral side
  input wire [W-1:0] per_hit,
  input wire [W-1:0] per_out,
  input wire [W-1:0] per_oe,
  // Overrides
  input wire [W-1:0] force_en,
  input wire [W-1:0] force_val,
  input wire [W-1:0] ana,
  // Pin drive
  output reg [W-1:0] pin_out,
  output reg [W-1:0] pin_oe,
  output reg [W-1:0] pin_ana
);
  reg [W-1:0] next_out;
  reg [W-1:0] next_oe;
  integer i;

  always @* begin
    next_out = {W{1'b0}};
    next_oe = {W{1'b0}};
    for (i = 0; i < W; i = i + 1) begin
      if (force_en[i]) begin
        next_out[i] = force_val[i];
        next_oe[i] = 1'b1;
      end else if (ana[i]) begin
        // Analog pins float the digital driver
        next_oe[i] = 1'b0;
      end else if (sel[i]) begin
        // Selected but unclaimed pin stays an input
        next_out[i] = per_hit[i] & per_out[i];
        next_oe[i] = per_hit[i] & per_oe[i];
      end else begin
        next_out[i] = gpio_out[i];
        next_oe[i] = gpio_oe[i];
      end
    end
  end

  // one register stage to the pins
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= {W{1'b0}};
      pin_oe <= {W{1'b0}};
      pin_ana <= {W{1'b0}};
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      pin_ana <= ana & ~force_en;
    end
  end
endmodule

// [design/iopm_sync.v]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module iopm_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [design/iopm_top.v]
// Port pin mux: data latches, function select, locations, priority and test output
`timescale 1ns/10ps
`include "iopm_regs.vh"
module iopm_top (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Register byte access
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  // Register bit access
  input wire bit_wr,
  input wire [7:0] bit_addr,
  input wire bit_wdata,
  // Settings kept by neighbouring logic
  input wire [7:0] p0_dir,
  input wire [7:0] p1_dir,
  input wire [4:0] p2_dir,
  input wire [1:0] port0_priority,
  input wire slow_osc_select,
  input wire [7:0] test_output_config_a,
  input wire [7:0] test_output_config_b,
  input wire [7:0] test_output_config_c,
  // Radio status
  input wire buffer_nonempty_status,
  input wire rx_threshold_status,
  input wire frame_start_status,
  input wire channel_clear_status,
  // Serial unit zero
  input wire [3:0] serial_unit_zero_out,
  input wire [3:0] serial_unit_zero_oe,
  // Serial unit one
  input wire [3:0] serial_unit_one_out,
  input wire [3:0] serial_unit_one_oe,
  // Timer 1
  input wire [2:0] timer_a_out,
  input wire [2:0] timer_a_oe,
  // Timer 3
  input wire [1:0] timer_c_out,
  input wire [1:0] timer_c_oe,
  // Timer 4
  input wire [1:0] timer_d_out,
  input wire [1:0] timer_d_oe,
  // Port 0 pins
  input wire [7:0] p0_pin_in,
  output wire [7:0] p0_pin_out,
  output wire [7:0] p0_pin_oe,
  output wire [7:0] p0_analog,
  // Port 1 pins
  input wire [7:0] p1_pin_in,
  output wire [7:0] p1_pin_out,
  output wire [7:0] p1_pin_oe,
  // Port 2 pins
  input wire [4:0] p2_pin_in,
  output wire [4:0] p2_pin_out,
  output wire [4:0] p2_pin_oe,
  output wire [4:0] p2_analog,
  // Synchronised pin levels for peripherals
  output wire [7:0] p0_level,
  output wire [7:0] p1_level,
  output wire [4:0] p2_level
);
  // Candidate order in claim vectors
  localparam C_U0 = 0;
  localparam C_U1 = 1;
  localparam C_T1 = 2;
  localparam C_T3 = 3;
  localparam C_T4 = 4;

  reg [7:0] port0_data;
  reg [7:0] port1_data;
  reg [4:0] port2_data;
  reg [7:0] peripheral_location;
  reg [7:0] analog_input_enable;
  reg [7:0] port0_function_select;
  reg [7:0] port1_function_select;
  reg [7:0] port2_select_priority;

  wire [20:0] pin_sync;
  wire [7:0] bit_byte;
  wire [7:0] bit_mask;

  // Port 0 winner: order chosen by the neighbouring priority field
  function [4:0] iopm_p0_win;
    input [4:0] claim;
    input [1:0] pri;
    reg [4:0] w;
    begin
      w = 5'h00;
      case (pri)
        2'b00: begin
          if (claim[C_U0]) w[C_U0] = 1'b1;
          else if (claim[C_U1]) w[C_U1] = 1'b1;
          else if (claim[C_T1]) w[C_T1] = 1'b1;
        end
        2'b01: begin
          if (claim[C_U1]) w[C_U1] = 1'b1;
          else if (claim[C_T1]) w[C_T1] = 1'b1;
          else if (claim[C_U0]) w[C_U0] = 1'b1;
        end
        2'b10: begin
          if (claim[C_T1]) w[C_T1] = 1'b1;
          else if (claim[C_U1]) w[C_U1] = 1'b1;
          else if (claim[C_U0]) w[C_U0] = 1'b1;
        end
        default: begin
          if (claim[C_T1]) w[C_T1] = 1'b1;
          else if (claim[C_U0]) w[C_U0] = 1'b1;
          else if (claim[C_U1]) w[C_U1] = 1'b1;
        end
      endcase
      iopm_p0_win = w;
    end
  endfunction

  // Port 1 winner: a candidate wins when no other claimant beats it
  function [4:0] iopm_p1_win;
    input [4:0] claim;
    input [7:0] pri;
    reg [4:0] beat_u0;
    reg [4:0] beat_u1;
    reg [4:0] beat_t1;
    reg [4:0] beat_t3;
    reg [4:0] beat_t4;
    begin
      beat_u0 = 5'h00;
      beat_u0[C_U1] = pri[`IOPM_PRI_SERIAL_PAIR];
      beat_u0[C_T1] = pri[`IOPM_PRI_SERIAL0_TIMER1];
      beat_u1 = 5'h00;
      beat_u1[C_U0] = ~pri[`IOPM_PRI_SERIAL_PAIR];
      beat_u1[C_T3] = pri[`IOPM_PRI_SERIAL1_TIMER3];
      beat_t1 = 5'h00;
      beat_t1[C_U0] = ~pri[`IOPM_PRI_SERIAL0_TIMER1];
      beat_t1[C_U1] = 1'b1;
      beat_t1[C_T4] = pri[`IOPM_PRI_TIMER1_TIMER4];
      beat_t3 = 5'h00;
      beat_t3[C_U0] = 1'b1;
      beat_t3[C_U1] = ~pri[`IOPM_PRI_SERIAL1_TIMER3];
      beat_t3[C_T1] = 1'b1;
      beat_t4 = 5'h00;
      beat_t4[C_U0] = 1'b1;
      beat_t4[C_U1] = 1'b1;
      beat_t4[C_T1] = ~pri[`IOPM_PRI_TIMER1_TIMER4];
      beat_t4[C_T3] = 1'b1;
      iopm_p1_win[C_U0] = claim[C_U0] & ~|(claim & beat_u0);
      iopm_p1_win[C_U1] = claim[C_U1] & ~|(claim & beat_u1);
      iopm_p1_win[C_T1] = claim[C_T1] & ~|(claim & beat_t1);
      iopm_p1_win[C_T3] = claim[C_T3] & ~|(claim & beat_t3);
      iopm_p1_win[C_T4] = claim[C_T4] & ~|(claim & beat_t4);
    end
  endfunction

  // Bit access: the byte is the bit address with its low three bits cleared
  assign bit_byte = {bit_addr[7:3], 3'b000};
  assign bit_mask = 8'h01 << bit_addr[2:0];

  // register writes, byte write wins over bit write
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port0_data <= `IOPM_PORT0_DATA_RST;
      port1_data <= `IOPM_PORT1_DATA_RST;
      port2_data <= `IOPM_PORT2_DATA_RST;
      peripheral_location <= `IOPM_CFG_RST;
      analog_input_enable <= `IOPM_CFG_RST;
      port0_function_select <= `IOPM_CFG_RST;
      port1_function_select <= `IOPM_CFG_RST;
      port2_select_priority <= `IOPM_CFG_RST;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `IOPM_PORT0_DATA_ADDR: port0_data <= sfr_wdata;
        `IOPM_PORT1_DATA_ADDR: port1_data <= sfr_wdata;
        `IOPM_PORT2_DATA_ADDR: port2_data <= sfr_wdata[4:0];
        `IOPM_PERIPHERAL_LOCATION_ADDR: peripheral_location <= sfr_wdata & `IOPM_LOC_MASK;
        `IOPM_ANALOG_INPUT_ENABLE_ADDR: analog_input_enable <= sfr_wdata;
        `IOPM_PORT0_FUNCTION_SELECT_ADDR: port0_function_select <= sfr_wdata;
        `IOPM_PORT1_FUNCTION_SELECT_ADDR: port1_function_select <= sfr_wdata;
        `IOPM_PORT2_SELECT_PRIORITY_ADDR: port2_select_priority <= sfr_wdata & `IOPM_PORT2_SEL_MASK;
        default: port0_data <= port0_data;
      endcase
    end else if (bit_wr) begin
      case (bit_byte)
        `IOPM_PORT0_DATA_ADDR: port0_data <= bit_wdata ? (port0_data | bit_mask) : (port0_data & ~bit_mask);
        `IOPM_PORT1_DATA_ADDR: port1_data <= bit_wdata ? (port1_data | bit_mask) : (port1_data & ~bit_mask);
        `IOPM_PORT2_DATA_ADDR: port2_data <= bit_wdata ? (port2_data | bit_mask[4:0]) : (port2_data & ~bit_mask[4:0]);
        default: port2_data <= port2_data;
      endcase
    end
  end

  // Reads return pin levels for ports, stored values for configuration
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `IOPM_PORT0_DATA_ADDR: sfr_rdata <= p0_level;
        `IOPM_PORT1_DATA_ADDR: sfr_rdata <= p1_level;
        `IOPM_PORT2_DATA_ADDR: sfr_rdata <= {3'h0, p2_level};
        `IOPM_PERIPHERAL_LOCATION_ADDR: sfr_rdata <= peripheral_location;
        `IOPM_ANALOG_INPUT_ENABLE_ADDR: sfr_rdata <= analog_input_enable;
        `IOPM_PORT0_FUNCTION_SELECT_ADDR: sfr_rdata <= port0_function_select;
        `IOPM_PORT1_FUNCTION_SELECT_ADDR: sfr_rdata <= port1_function_select;
        `IOPM_PORT2_SELECT_PRIORITY_ADDR: sfr_rdata <= port2_select_priority;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Pins come from outside the clock domain
  iopm_sync #(.W(21)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({p2_pin_in, p1_pin_in, p0_pin_in}),
    .dout(pin_sync)
  );
  assign p0_level = pin_sync[7:0];
  assign p1_level = pin_sync[15:8];
  assign p2_level = pin_sync[20:16];

  // Claims per pin: one bit per candidate, with its output and enable
  reg [4:0] p0_claim [0:7];
  reg [4:0] p0_cout [0:7];
  reg [4:0] p0_coe [0:7];
  reg [4:0] p1_claim [0:7];
  reg [4:0] p1_cout [0:7];
  reg [4:0] p1_coe [0:7];
  reg [4:0] p2_hit;
  reg [4:0] p2_out;
  reg [4:0] p2_oe;
  wire loc_u0;
  wire loc_u1;
  wire loc_t1;
  wire loc_t3;
  wire loc_t4;
  integer k;

  // location bits, 0 is alternative 1, 1 is alternative 2
  assign loc_u0 = peripheral_location[`IOPM_LOC_SERIAL_ZERO];
  assign loc_u1 = peripheral_location[`IOPM_LOC_SERIAL_ONE];
  assign loc_t1 = peripheral_location[`IOPM_LOC_TIMER_A];
  assign loc_t3 = peripheral_location[`IOPM_LOC_TIMER_C];
  assign loc_t4 = peripheral_location[`IOPM_LOC_TIMER_D];

  always @* begin
    for (k = 0; k < 8; k = k + 1) begin
      p0_claim[k] = 5'h00;
      p0_cout[k] = 5'h00;
      p0_coe[k] = 5'h00;
      p1_claim[k] = 5'h00;
      p1_cout[k] = 5'h00;
      p1_coe[k] = 5'h00;
    end
    p2_hit = 5'h00;
    p2_out = 5'h00;
    p2_oe = 5'h00;
    // serial units on port 0 pins 2-5 or port 1
    for (k = 0; k < 4; k = k + 1) begin
      if (!loc_u0) begin
        p0_claim[k+2][C_U0] = 1'b1;
        p0_cout[k+2][C_U0] = serial_unit_zero_out[k];
        p0_coe[k+2][C_U0] = serial_unit_zero_oe[k];
      end else begin
        p1_claim[k+2][C_U0] = 1'b1;
        p1_cout[k+2][C_U0] = serial_unit_zero_out[k];
        p1_coe[k+2][C_U0] = serial_unit_zero_oe[k];
      end
      if (!loc_u1) begin
        p0_claim[k+2][C_U1] = 1'b1;
        p0_cout[k+2][C_U1] = serial_unit_one_out[k];
        p0_coe[k+2][C_U1] = serial_unit_one_oe[k];
      end else begin
        p1_claim[k+4][C_U1] = 1'b1;
        p1_cout[k+4][C_U1] = serial_unit_one_out[k];
        p1_coe[k+4][C_U1] = serial_unit_one_oe[k];
      end
    end
    // timer 1 channels on port 0 pins 2-4 or port 1 pins 2-0
    for (k = 0; k < 3; k = k + 1) begin
      if (!loc_t1) begin
        p0_claim[k+2][C_T1] = 1'b1;
        p0_cout[k+2][C_T1] = timer_a_out[k];
        p0_coe[k+2][C_T1] = timer_a_oe[k];
      end else begin
        p1_claim[2-k][C_T1] = 1'b1;
        p1_cout[2-k][C_T1] = timer_a_out[k];
        p1_coe[2-k][C_T1] = timer_a_oe[k];
      end
    end
    for (k = 0; k < 2; k = k + 1) begin
      p1_claim[loc_t3 ? k+6 : k+3][C_T3] = 1'b1;
      p1_cout[loc_t3 ? k+6 : k+3][C_T3] = timer_c_out[k];
      p1_coe[loc_t3 ? k+6 : k+3][C_T3] = timer_c_oe[k];
      if (!loc_t4) begin
        p1_claim[k][C_T4] = 1'b1;
        p1_cout[k][C_T4] = timer_d_out[k];
        p1_coe[k][C_T4] = timer_d_oe[k];
      end else begin
        p2_hit[k*3] = 1'b1;
        p2_out[k*3] = timer_d_out[k];
        p2_oe[k*3] = timer_d_oe[k];
      end
    end
  end

  wire [7:0] p0_hit;
  wire [7:0] p0_out;
  wire [7:0] p0_oe;
  wire [7:0] p1_hit;
  wire [7:0] p1_out;
  wire [7:0] p1_oe;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_arb
      wire [4:0] w0;
      wire [4:0] w1;
      assign w0 = iopm_p0_win(p0_claim[g], port0_priority);
      assign w1 = iopm_p1_win(p1_claim[g], port2_select_priority);
      assign p0_hit[g] = |w0;
      assign p0_out[g] = |(w0 & p0_cout[g]);
      assign p0_oe[g] = |(w0 & p0_coe[g]);
      assign p1_hit[g] = |w1;
      assign p1_out[g] = |(w1 & p1_cout[g]);
      assign p1_oe[g] = |(w1 & p1_coe[g]);
    end
  endgenerate

  // each config register enables its pins; inversion flips polarity
  wire [3:0] test_en;
  wire [3:0] test_inv;
  wire [3:0] test_val;
  assign test_en = {test_output_config_c[`IOPM_TOC_EN_BIT], test_output_config_b[`IOPM_TOC_EN_BIT],
                    test_output_config_a[`IOPM_TOC_EN_BIT], test_output_config_a[`IOPM_TOC_EN_BIT]};
  assign test_inv = {test_output_config_c[`IOPM_TOC_INV_BIT], test_output_config_b[`IOPM_TOC_INV_BIT],
                     test_output_config_a[`IOPM_TOC_INV_BIT], test_output_config_a[`IOPM_TOC_INV_BIT]};
  assign test_val = {channel_clear_status, frame_start_status, rx_threshold_status, buffer_nonempty_status} ^ test_inv;

  // port 2 select bits map to pins 4, 3 and 0
  wire [4:0] p2_sel;
  assign p2_sel = {port2_select_priority[`IOPM_SEL_P2_PIN4], port2_select_priority[`IOPM_SEL_P2_PIN3],
                   2'b00, port2_select_priority[`IOPM_SEL_P2_PIN0]};

  // analog enable reaches the driver ahead of the select bit
  iopm_pin_drv #(.W(8)) u_drv0 (
    .mclk(mclk),
    .rst_n(rst_n),
    .gpio_out(port0_data),
    .gpio_oe(p0_dir),
    .sel(port0_function_select),
    .per_hit(p0_hit),
    .per_out(p0_out),
    .per_oe(p0_oe),
    .force_en(8'h00),
    .force_val(8'h00),
    .ana(analog_input_enable),
    .pin_out(p0_pin_out),
    .pin_oe(p0_pin_oe),
    .pin_ana(p0_analog)
  );

  // test output forced on pins 7-4 above every select
  iopm_pin_drv #(.W(8)) u_drv1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .gpio_out(port1_data),
    .gpio_oe(p1_dir),
    .sel(port1_function_select),
    .per_hit(p1_hit),
    .per_out(p1_out),
    .per_oe(p1_oe),
    .force_en({test_en, 4'h0}),
    .force_val({test_val, 4'h0}),
    .ana(8'h00),
    .pin_out(p1_pin_out),
    .pin_oe(p1_pin_oe),
    .pin_ana()
  );

  // slow crystal owns pins 3 and 4 while its select is low
  iopm_pin_drv #(.W(5)) u_drv2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .gpio_out(port2_data),
    .gpio_oe(p2_dir),
    .sel(p2_sel),
    .per_hit(p2_hit),
    .per_out(p2_out),
    .per_oe(p2_oe),
    .force_en(5'h00),
    .force_val(5'h00),
    .ana({~slow_osc_select, ~slow_osc_select, 3'h0}),
    .pin_out(p2_pin_out),
    .pin_oe(p2_pin_oe),
    .pin_ana(p2_analog)
  );
endmodule

// [dv/iopm_periph_model.sv]
// Peripheral units and package pins facing the port pin mux
`timescale 1ns/10ps
module iopm_periph_model (
  // Which units enable their output drivers: serial 0, serial 1, timer 1, 3, 4
  input wire logic [4:0] unit_en,
  // Peripheral drive
  output wire logic [3:0] serial_unit_zero_out,
  output wire logic [3:0] serial_unit_zero_oe,
  output wire logic [3:0] serial_unit_one_out,
  output wire logic [3:0] serial_unit_one_oe,
  output wire logic [2:0] timer_a_out,
  output wire logic [2:0] timer_a_oe,
  output wire logic [1:0] timer_c_out,
  output wire logic [1:0] timer_c_oe,
  output wire logic [1:0] timer_d_out,
  output wire logic [1:0] timer_d_oe,
  // Pins
  input wire logic [7:0] p0_pin_out,
  input wire logic [7:0] p0_pin_oe,
  input wire logic [7:0] p1_pin_out,
  input wire logic [7:0] p1_pin_oe,
  input wire logic [4:0] p2_pin_out,
  input wire logic [4:0] p2_pin_oe,
  output wire logic [7:0] p0_pin_in,
  output wire logic [7:0] p1_pin_in,
  output wire logic [4:0] p2_pin_in
);
  // Units paired by a port 1 priority bit drive opposite levels so the winner of a shared pin shows
  assign serial_unit_zero_out = 4'hf;
  assign serial_unit_zero_oe = {4{unit_en[0]}};
  assign serial_unit_one_out = 4'h0;
  assign serial_unit_one_oe = {4{unit_en[1]}};
  assign timer_a_out = 3'h0;
  assign timer_a_oe = {3{unit_en[2]}};
  assign timer_c_out = 2'h3;
  assign timer_c_oe = {2{unit_en[3]}};
  assign timer_d_out = 2'h3;
  assign timer_d_oe = {2{unit_en[4]}};
  // Undriven pins sit at the pull-up level chosen after reset
  assign p0_pin_in = p0_pin_out | ~p0_pin_oe;
  assign p1_pin_in = p1_pin_out | ~p1_pin_oe;
  assign p2_pin_in = p2_pin_out | ~p2_pin_oe;
endmodule

// [dv/iopm_top_monitor.sv]
// Assertions on the port pin mux top-level ports
`timescale 1ns/10ps
module iopm_top_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Test output and status
  input wire logic slow_osc_select,
  input wire logic [7:0] test_output_config_a,
  input wire logic [7:0] test_output_config_b,
  input wire logic [7:0] test_output_config_c,
  input wire logic buffer_nonempty_status,
  input wire logic rx_threshold_status,
  input wire logic frame_start_status,
  input wire logic channel_clear_status,
  // Pins
  input wire logic [7:0] p0_pin_oe,
  input wire logic [7:0] p0_analog,
  input wire logic [7:0] p1_pin_out,
  input wire logic [7:0] p1_pin_oe,
  input wire logic [4:0] p2_analog
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_test_out_a: assert property (
    test_output_config_a[6] |=> p1_pin_oe[5:4] == 2'b11 && p1_pin_out[5:4] ==
    ({$past(rx_threshold_status), $past(buffer_nonempty_status)} ^ {2{$past(test_output_config_a[0])}}))
    else $error("test output pins 5 and 4 wrong");
  chk_test_out_b: assert property (
    test_output_config_b[6] |=> p1_pin_oe[6] == 1'b1
    && p1_pin_out[6] == ($past(frame_start_status) ^ $past(test_output_config_b[0])))
    else $error("test output pin 6 wrong");
  chk_test_out_c: assert property (
    test_output_config_c[6] |=> p1_pin_oe[7] == 1'b1
    && p1_pin_out[7] == ($past(channel_clear_status) ^ $past(test_output_config_c[0])))
    else $error("test output pin 7 wrong");
  chk_analog_write: assert property (
    sfr_wr && sfr_addr == 8'hf2 ##1 !(sfr_wr && sfr_addr == 8'hf2) |=> p0_analog == $past(sfr_wdata, 2))
    else $error("analog enables do not follow write");
  chk_analog_undriven: assert property (
    (p0_analog & p0_pin_oe) == 8'h00)
    else $error("analog pin still driven");
  chk_loc_unused: assert property (
    sfr_rd && sfr_addr == 8'hf1 |=> sfr_rdata[7] == 1'b0 && sfr_rdata[3:2] == 2'b00)
    else $error("location unused bits not zero");
  chk_sel_unused: assert property (
    sfr_rd && sfr_addr == 8'hf5 |=> sfr_rdata[7] == 1'b0)
    else $error("select bit 7 not zero");
  chk_port2_upper: assert property (
    sfr_rd && sfr_addr == 8'ha0 |=> sfr_rdata[7:5] == 3'b000)
    else $error("port 2 upper bits not zero");
  chk_slow_osc_pins: assert property (
    !slow_osc_select |=> p2_analog[4:3] == 2'b11)
    else $error("crystal pins not analog");
  chk_reset_release: assert property (
    $rose(rst_n) |=> p0_analog == 8'h00)
    else $error("analog enables not cleared by reset");
endmodule
bind iopm_top iopm_top_monitor u_mon (.mclk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
  .slow_osc_select, .test_output_config_a, .test_output_config_b, .test_output_config_c,
  .buffer_nonempty_status, .rx_threshold_status, .frame_start_status, .channel_clear_status,
  .p0_pin_oe, .p0_analog, .p1_pin_out, .p1_pin_oe, .p2_analog);

// [dv/iopm_top_tb.sv]
// Self-checking bench for the port pin mux
`timescale 1ns/10ps
module iopm_top_tb;
  logic mclk, rst_n, sfr_wr, sfr_rd, bit_wr, bit_wdata, slow_osc_select;
  logic buffer_nonempty_status, rx_threshold_status, frame_start_status, channel_clear_status;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, p0_dir, p1_dir;
  logic [7:0] test_output_config_a, test_output_config_b, test_output_config_c;
  logic [4:0] p2_dir, unit_en;
  logic [1:0] port0_priority;
  wire [3:0] serial_unit_zero_out, serial_unit_zero_oe, serial_unit_one_out, serial_unit_one_oe;
  wire [2:0] timer_a_out, timer_a_oe;
  wire [1:0] timer_c_out, timer_c_oe, timer_d_out, timer_d_oe;
  wire [7:0] p0_pin_in, p0_pin_out, p0_pin_oe, p0_analog, p0_level, p1_pin_in, p1_pin_out, p1_pin_oe, p1_level;
  wire [4:0] p2_pin_in, p2_pin_out, p2_pin_oe, p2_analog, p2_level;
  int n_mismatch, checked;
  // Row: location, analog, p0 select, p1 select, p2 select, units, mask, expected
  logic [108:0] rows [11];
  logic [7:0] ra [9] = '{8'h80, 8'h90, 8'ha0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'h81};
  logic [7:0] re [9] = '{8'hff, 8'hff, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  iopm_top dut (.mclk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .bit_wr, .bit_addr,
    .bit_wdata, .p0_dir, .p1_dir, .p2_dir, .port0_priority, .slow_osc_select, .test_output_config_a,
    .test_output_config_b, .test_output_config_c, .buffer_nonempty_status, .rx_threshold_status,
    .frame_start_status, .channel_clear_status, .serial_unit_zero_out, .serial_unit_zero_oe,
    .serial_unit_one_out, .serial_unit_one_oe, .timer_a_out, .timer_a_oe, .timer_c_out, .timer_c_oe,
    .timer_d_out, .timer_d_oe, .p0_pin_in, .p0_pin_out, .p0_pin_oe, .p0_analog, .p1_pin_in, .p1_pin_out,
    .p1_pin_oe, .p2_pin_in, .p2_pin_out, .p2_pin_oe, .p2_analog, .p0_level, .p1_level, .p2_level);
  iopm_periph_model u_model (.unit_en, .serial_unit_zero_out, .serial_unit_zero_oe, .serial_unit_one_out,
    .serial_unit_one_oe, .timer_a_out, .timer_a_oe, .timer_c_out, .timer_c_oe, .timer_d_out, .timer_d_oe,
    .p0_pin_out, .p0_pin_oe, .p1_pin_out, .p1_pin_oe, .p2_pin_out, .p2_pin_oe, .p0_pin_in, .p1_pin_in,
    .p2_pin_in);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  // Read data is registered at the read edge, so it is settled at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    check(sfr_rdata, exp, "register read");
    cyc(1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Guards against a hung run
  initial begin
    #200000;
    n_mismatch++;
    summarize;
  end
  initial begin
    {rst_n, sfr_wr, sfr_rd, bit_wr, bit_wdata, sfr_addr, sfr_wdata, bit_addr} = '0;
    {p0_dir, p1_dir, p2_dir, port0_priority, unit_en} = '0;
    {test_output_config_a, test_output_config_b, test_output_config_c} = '0;
    {buffer_nonempty_status, rx_threshold_status, frame_start_status, channel_clear_status} = 4'b1011;
    slow_osc_select = 1'b1;
    rows = '{{8'h03, 8'h00, 8'h00, 8'hff, 8'h00, 5'h03, 32'h30300000, 32'h30300000},
      {8'h03, 8'h00, 8'h00, 8'hff, 8'h40, 5'h03, 32'h30300000, 32'h00300000},
      {8'h22, 8'h00, 8'h00, 8'hff, 8'h00, 5'h0a, 32'hc0c00000, 32'h00c00000},
      {8'h22, 8'h00, 8'h00, 8'hff, 8'h20, 5'h0a, 32'hc0c00000, 32'hc0c00000},
      {8'h40, 8'h00, 8'h00, 8'hff, 8'h00, 5'h14, 32'h03030000, 32'h00030000},
      {8'h40, 8'h00, 8'h00, 8'hff, 8'h10, 5'h14, 32'h03030000, 32'h03030000},
      {8'h41, 8'h00, 8'h00, 8'hff, 8'h00, 5'h05, 32'h04040000, 32'h04040000},
      {8'h41, 8'h00, 8'h00, 8'hff, 8'h08, 5'h05, 32'h04040000, 32'h00040000},
      {8'h00, 8'h00, 8'h3c, 8'h00, 8'h00, 5'h01, 32'h00003c3c, 32'h00003c3c},
      {8'h00, 8'h3c, 8'h3c, 8'h00, 8'h00, 5'h01, 32'h0000003c, 32'h00000000},
      {8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 5'h03, 32'h00300000, 32'h00000000}};
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      for (int k = 0; k < 5; k++) begin
        wr(8'(8'hf1 + k), rows[i][108 - 8 * k -: 8]);
      end
      unit_en = rows[i][68:64];
      cyc(3);
      check({p1_pin_out, p1_pin_oe, p0_pin_out, p0_pin_oe} & rows[i][63:32], rows[i][31:0], "routing");
    end
    $display("routing rows done");
    wr(8'hf1, 8'hff);
    rd(8'hf1, 8'h73);
    wr(8'hf5, 8'hff);
    rd(8'hf5, 8'h7f);
    wr(8'h81, 8'hff);
    rd(8'h81, 8'h00);
    $display("reserved bits done");
    // Mid-run reset; pins are driven so port reads show the latch reset values
    unit_en = 5'h00;
    {p0_dir, p1_dir, p2_dir} = {8'hff, 8'hff, 5'h1f};
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    foreach (ra[i]) begin
      rd(ra[i], re[i]);
    end
    $display("reset values done");
    wr(8'h80, 8'h5a);
    wr(8'h90, 8'hc3);
    wr(8'ha0, 8'he5);
    {bit_addr, bit_wdata, bit_wr} = {8'h97, 1'b0, 1'b1};
    cyc(1);
    bit_wr = 1'b0;
    cyc(4);
    rd(8'h80, 8'h5a);
    rd(8'h90, 8'h43);
    rd(8'ha0, 8'h05);
    $display("port data done");
    p1_dir = 8'h00;
    unit_en = 5'h1f;
    wr(8'hf4, 8'hff);
    wr(8'hf1, 8'h03);
    {test_output_config_a, test_output_config_b, test_output_config_c} = {8'h41, 8'h40, 8'h41};
    cyc(2);
    check({p1_pin_out[7:4], p1_pin_oe[7:4]}, 8'h6f, "test output");
    {buffer_nonempty_status, rx_threshold_status, frame_start_status, channel_clear_status} = 4'b0100;
    cyc(2);
    check({p1_pin_out[7:4], p1_pin_oe[7:4]}, 8'h9f, "test output");
    {test_output_config_a, test_output_config_b, test_output_config_c} = '0;
    $display("test output done");
    p2_dir = 5'h00;
    slow_osc_select = 1'b0;
    wr(8'hf5, 8'h07);
    cyc(2);
    check(p2_analog[4:3], 2'b11, "crystal pins");
    {slow_osc_select, port0_priority} = 3'b110;
    wr(8'hf1, 8'h10);
    wr(8'hf5, 8'h03);
    wr(8'hf3, 8'h3c);
    cyc(2);
    check({p2_pin_oe[3], p2_pin_oe[0], p2_pin_out[3], p2_pin_out[0]}, 4'hf, "port 2 select");
    check({p0_pin_out[5:2], p0_pin_oe[5:2]}, 8'h0f, "port 0 order");
    $display("port 2 done");
    summarize;
  end
endmodule
